// [cl_pkg.sv]
package cl_pkg;
   // Clock and time base
   localparam int CLK_HZ = 100_000_000;
   localparam int CLK_PERIOD_NS = 10;
   localparam int CHECK_UNIT_NS = 100_000_000;  // Silence check step, 0.1 s
   localparam int WAIT_UNIT_NS = 1_000_000;     // Reply wait step, 1 ms
   localparam int CHECK_UNIT_CYC = CHECK_UNIT_NS / CLK_PERIOD_NS;
   localparam int WAIT_UNIT_CYC = WAIT_UNIT_NS / CLK_PERIOD_NS;
   // Bit rates
   localparam int BAUD_0 = 4800;
   localparam int BAUD_1 = 9600;
   localparam int BAUD_2 = 19200;
   localparam int BAUD_3 = 38400;
   // Register byte addresses
   localparam logic [7:0] A_CFG = 8'h00;
   localparam logic [7:0] A_RETRY = 8'h04;
   localparam logic [7:0] A_CHECK = 8'h08;
   localparam logic [7:0] A_STOP = 8'h0c;
   localparam logic [7:0] A_WAIT = 8'h10;
   localparam logic [7:0] A_STAT = 8'h14;
   localparam logic [7:0] A_CTRL = 8'h18;
   // Field layout of the configuration and control registers
   localparam int F_STN = 0;
   localparam int F_RATE = 5;
   localparam int F_CH8 = 7;
   localparam int F_STOP2 = 8;
   localparam int F_PAR = 9;
   localparam int F_WAITEN = 11;
   localparam int F_STORE = 12;
   localparam int F_CLR = 0;
   // Status layout
   localparam int S_ALM = 0;
   localparam int S_WARN = 1;
   localparam int S_DECEL = 2;
   localparam int S_COAST = 3;
   localparam int S_HTMP = 4;
   localparam int S_REPLY = 5;
   localparam int S_FST = 8;
   localparam int S_ERRC = 16;
   // Special values and reset values
   localparam logic [13:0] NO_LIMIT = 14'h270f;  // 9999
   localparam logic [13:0] RETRY_RST = 14'h0001;
   localparam logic [13:0] CHECK_RST = 14'h0000;
   localparam logic [1:0] PAR_NONE = 2'h0;
   localparam logic [1:0] PAR_ODD = 2'h1;
   localparam logic [1:0] PAR_EVEN = 2'h2;
   localparam logic [1:0] SM_COAST = 2'h0;
   localparam logic [1:0] SM_DECEL = 2'h1;
   localparam logic [1:0] SM_AUTO = 2'h2;
   localparam logic [7:0] TRIP_CODE_DEF = 8'h5a;  // Arbitrary value
   localparam logic [11:0] FRAME_IDLE = 12'hfff;

   typedef enum logic [2:0] {
      L_IDLE = 3'b001,
      L_WAIT = 3'b010,
      L_REPLY = 3'b100
   } cl_link_t;

   typedef enum logic [4:0] {
      F_OK = 5'b00001,
      F_COASTING = 5'b00010,
      F_DECEL = 5'b00100,
      F_TRIP = 5'b01000,
      F_AUTO = 5'b10000
   } cl_fault_t;

   // Configuration register: station, character framing, reply wait enable and storage select
   typedef struct packed {
      logic store_ram;  // First member is the top bit of the field layout
      logic wait_en;
      logic [1:0] par;
      logic stop2;
      logic ch8;
      logic [1:0] rate;
      logic [4:0] station;
   } cl_cfg_t;

   // Finished request reported by the message parser
   typedef struct packed {
      logic done;
      logic ack;
      logic sum_err;
      logic [4:0] station;
   } cl_req_t;

   // Serial shifter state
   typedef struct packed {
      logic busy;
      logic [15:0] cnt;
      logic [3:0] idx;
      logic [11:0] sh;
   } cl_ser_t;
endpackage

// [cl_link_ctrl.sv]
`timescale 1ns/100ps
module cl_link_ctrl import cl_pkg::*; #(
   parameter int CHECK_CYC = CHECK_UNIT_CYC,
   parameter int WAIT_CYC = WAIT_UNIT_CYC
) (
   input wire logic CLK_SYS,
   input wire logic RST,
   input wire logic [7:0] ADDR,
   input wire logic [31:0] WDATA,
   input wire logic WR,
   input wire logic RD,
   output logic [31:0] RDATA,
   input wire logic RXD,
   output logic TXD,
   output logic LINK_DE_N,
   output logic RX_VALID,
   output logic [7:0] RX_DATA,
   input wire cl_req_t REQ,
   input wire logic TX_VALID,
   input wire logic [7:0] TX_DATA,
   input wire logic TX_LAST,
   output logic TX_READY,
   output logic REPLY_RETRY,
   input wire logic NET_MODE,
   input wire logic CMD_UPD,
   input wire logic CMD_RUN,
   input wire logic [15:0] CMD_SPEED,
   input wire logic STOPPED,
   output logic RUN_OUT,
   output logic [15:0] SPEED_OUT,
   output logic DECEL_STOP,
   output logic COAST_STOP,
   output logic RESTART,
   output logic FAULT_ALARM,
   output logic LINK_WARN,
   output logic [7:0] TRIP_CODE,
   output logic HIST_WR,
   output logic HIST_TEMP,
   output logic HIST_RESTORE,
   input wire logic PARAM_WR,
   output logic NV_WR,
   output logic RAM_WR
);
   typedef struct packed {
      cl_cfg_t cfg;
      logic [13:0] retry_lim;
      logic [13:0] check_iv;
      logic [1:0] smode;
      logic [7:0] wait_ms;
      logic [31:0] rdata;
      cl_ser_t rx;
      logic rx_v;
      logic [7:0] rx_d;
      logic req_err;
      cl_ser_t tx;
      logic tx_last;
      cl_link_t link;
      logic [7:0] wait_left;
      logic [16:0] ms_cnt;
      logic retry_rep;
      logic [13:0] err_cnt;
      logic warn;
      logic [23:0] tick_cnt;
      logic [13:0] sil_cnt;
      logic sil_arm;
      cl_fault_t fst;
      logic hist_wr;
      logic hist_rst;
      logic restart;
      logic nv_wr;
      logic ram_wr;
      logic cmd_run;
      logic [15:0] cmd_speed;
   } cl_state_t;

   cl_state_t r_reg;
   cl_state_t r_next;

   // Bit period in clock cycles for a rate code
   function automatic logic [15:0] bit_cycles(input logic [1:0] rate);
      int b;
      case (rate)
         2'h0: b = CLK_HZ / BAUD_0;
         2'h1: b = CLK_HZ / BAUD_1;
         2'h2: b = CLK_HZ / BAUD_2;
         default: b = CLK_HZ / BAUD_3;
      endcase
      return b[15:0];
   endfunction

   // Bits per character: start, data, optional parity, stops
   function automatic logic [3:0] frame_bits(input cl_cfg_t c);
      logic [3:0] n;
      n = 4'h9;
      if (c.ch8) begin
         n = n + 4'h1;
      end
      if (c.par != PAR_NONE) begin
         n = n + 4'h1;
      end
      if (c.stop2) begin
         n = n + 4'h1;
      end
      return n;
   endfunction

   // Parity bit to send for a character
   function automatic logic par_bit(input cl_cfg_t c, input logic [7:0] d);
      logic [7:0] m;
      m = c.ch8 ? d : {1'b0, d[6:0]};
      return (^m) ^ (c.par == PAR_ODD);
   endfunction

   logic [3:0] nbits;
   logic [3:0] dlen;
   logic [15:0] bdiv;
   logic trip_evt;
   logic clear_evt;
   logic good_req;
   logic bad_req;
   logic [7:0] rd8;
   logic [11:0] frm;
   logic pbit;
   logic fr_err;

   assign nbits = frame_bits(r_reg.cfg);
   assign dlen = r_reg.cfg.ch8 ? 4'h8 : 4'h7;
   assign bdiv = bit_cycles(r_reg.cfg.rate);

   always_comb begin
      r_next = r_reg;
      trip_evt = 1'b0;
      clear_evt = 1'b0;
      good_req = 1'b0;
      bad_req = 1'b0;
      rd8 = 8'h00;
      frm = FRAME_IDLE;
      pbit = 1'b0;
      fr_err = 1'b0;
      r_next.rx_v = 1'b0;
      r_next.hist_wr = 1'b0;
      r_next.hist_rst = 1'b0;
      r_next.restart = 1'b0;
      r_next.nv_wr = 1'b0;
      r_next.ram_wr = 1'b0;

      // Register writes
      if (WR) begin
         case (ADDR)
            A_CFG: r_next.cfg = WDATA[F_STORE:F_STN];
            A_RETRY: r_next.retry_lim = WDATA[13:0];
            A_CHECK: r_next.check_iv = WDATA[13:0];
            A_STOP: r_next.smode = WDATA[1:0];
            A_WAIT: r_next.wait_ms = WDATA[7:0];
            A_CTRL: clear_evt = WDATA[F_CLR];
            default: ;
         endcase
      end

      // Register reads, data stand in the next cycle
      r_next.rdata = 32'h0000_0000;
      if (RD) begin
         case (ADDR)
            A_CFG: r_next.rdata[F_STORE:F_STN] = r_reg.cfg;
            A_RETRY: r_next.rdata[13:0] = r_reg.retry_lim;
            A_CHECK: r_next.rdata[13:0] = r_reg.check_iv;
            A_STOP: r_next.rdata[1:0] = r_reg.smode;
            A_WAIT: r_next.rdata[7:0] = r_reg.wait_ms;
            A_STAT: begin
               r_next.rdata[S_ALM] = FAULT_ALARM;
               r_next.rdata[S_WARN] = r_reg.warn;
               r_next.rdata[S_DECEL] = DECEL_STOP;
               r_next.rdata[S_COAST] = COAST_STOP;
               r_next.rdata[S_HTMP] = HIST_TEMP;
               r_next.rdata[S_REPLY] = (r_reg.link == L_REPLY);
               r_next.rdata[S_FST +: 5] = r_reg.fst;
               r_next.rdata[S_ERRC +: 14] = r_reg.err_cnt;
            end
            default: ;
         endcase
      end

      // Receiver, no new start bit taken while our own driver is on
      if (!r_reg.rx.busy) begin
         if (!RXD && !r_reg.tx.busy) begin
            r_next.rx.busy = 1'b1;
            r_next.rx.cnt = {1'b0, bdiv[15:1]};
            r_next.rx.idx = 4'h0;
            r_next.rx.sh = FRAME_IDLE;
         end
      end else if (r_reg.rx.cnt != 16'h0000) begin
         r_next.rx.cnt = r_reg.rx.cnt - 16'h0001;
      end else if (r_reg.rx.idx == 4'h0 && RXD) begin
         r_next.rx.busy = 1'b0;  // False start bit
      end else begin
         r_next.rx.sh[r_reg.rx.idx] = RXD;
         r_next.rx.idx = r_reg.rx.idx + 4'h1;
         r_next.rx.cnt = bdiv - 16'h0001;
         if (r_reg.rx.idx == nbits - 4'h1) begin
            frm = r_next.rx.sh;
            rd8 = r_reg.cfg.ch8 ? frm[8:1] : {1'b0, frm[7:1]};
            pbit = frm[dlen + 4'h1];
            fr_err = !frm[nbits - 4'h1];
            if (r_reg.cfg.stop2 && !frm[nbits - 4'h2]) begin
               fr_err = 1'b1;
            end
            if (r_reg.cfg.par != PAR_NONE && pbit != par_bit(r_reg.cfg, rd8)) begin
               fr_err = 1'b1;
            end
            r_next.rx.busy = 1'b0;
            r_next.rx_v = 1'b1;
            r_next.rx_d = rd8;
            r_next.req_err = r_reg.req_err | fr_err;
         end
      end

      // Request completion, addressed to this station or not
      if (REQ.done) begin
         r_next.req_err = 1'b0;
         r_next.sil_cnt = 14'h0000;
         if (NET_MODE) begin
            r_next.sil_arm = 1'b1;
         end
         if (REQ.station == r_reg.cfg.station && !REQ.ack
               && r_reg.link == L_IDLE) begin
            if (r_reg.req_err || REQ.sum_err) begin
               bad_req = 1'b1;
            end else begin
               good_req = 1'b1;
            end
            r_next.retry_rep = bad_req;
            r_next.wait_left = r_reg.wait_ms;
            r_next.ms_cnt = 17'(WAIT_CYC - 1);
            r_next.link = r_reg.cfg.wait_en ? L_WAIT : L_REPLY;
         end
      end

      // Reply waiting time
      if (r_reg.link == L_WAIT) begin
         if (r_reg.wait_left == 8'h00) begin
            r_next.link = L_REPLY;
         end else if (r_reg.ms_cnt == 17'h00000) begin
            r_next.ms_cnt = 17'(WAIT_CYC - 1);
            r_next.wait_left = r_reg.wait_left - 8'h01;
         end else begin
            r_next.ms_cnt = r_reg.ms_cnt - 17'h00001;
         end
      end

      // Transmitter
      if (TX_READY && TX_VALID) begin
         frm = FRAME_IDLE;
         frm[0] = 1'b0;
         for (int i = 0; i < 8; i++) begin
            if (4'(i) < dlen) begin
               frm[i + 1] = TX_DATA[i];
            end
         end
         if (r_reg.cfg.par != PAR_NONE) begin
            frm[dlen + 4'h1] = par_bit(r_reg.cfg, TX_DATA);
         end
         r_next.tx.busy = 1'b1;
         r_next.tx.sh = frm;
         r_next.tx.idx = nbits - 4'h1;
         r_next.tx.cnt = bdiv - 16'h0001;
         r_next.tx_last = TX_LAST;
      end else if (r_reg.tx.busy) begin
         if (r_reg.tx.cnt != 16'h0000) begin
            r_next.tx.cnt = r_reg.tx.cnt - 16'h0001;
         end else if (r_reg.tx.idx != 4'h0) begin
            r_next.tx.sh = {1'b1, r_reg.tx.sh[11:1]};
            r_next.tx.idx = r_reg.tx.idx - 4'h1;
            r_next.tx.cnt = bdiv - 16'h0001;
         end else begin
            r_next.tx.busy = 1'b0;
            if (r_reg.tx_last) begin
               r_next.link = L_IDLE;
            end
         end
      end

      // Consecutive error counting
      if (good_req) begin
         r_next.err_cnt = 14'h0000;
         r_next.warn = 1'b0;
      end else if (bad_req) begin
         if (r_reg.retry_lim == NO_LIMIT) begin
            r_next.warn = 1'b1;
         end else begin
            r_next.err_cnt = r_reg.err_cnt + 14'h0001;
            trip_evt = (r_next.err_cnt >= r_reg.retry_lim);
         end
      end

      // Silence check in 0.1 s steps
      if (!NET_MODE || r_reg.check_iv == NO_LIMIT) begin
         r_next.sil_arm = 1'b0;
         r_next.sil_cnt = 14'h0000;
      end else if (r_reg.check_iv == 14'h0000) begin
         trip_evt = trip_evt | r_reg.sil_arm;
      end else if (r_reg.sil_arm && !REQ.done) begin
         if (r_reg.tick_cnt == 24'h000000) begin
            r_next.tick_cnt = 24'(CHECK_CYC - 1);
            r_next.sil_cnt = r_reg.sil_cnt + 14'h0001;
         end else begin
            r_next.tick_cnt = r_reg.tick_cnt - 24'h000001;
         end
         if (r_reg.sil_cnt >= r_reg.check_iv) begin
            trip_evt = 1'b1;
            r_next.sil_cnt = 14'h0000;
         end
      end
      if (REQ.done) begin
         r_next.tick_cnt = 24'(CHECK_CYC - 1);
      end

      // Fault sequencing by stop mode
      case (r_reg.fst)
         F_OK: begin
            if (trip_evt) begin
               case (r_reg.smode)
                  SM_DECEL: r_next.fst = F_DECEL;
                  SM_AUTO: r_next.fst = F_AUTO;
                  default: begin
                     r_next.fst = F_COASTING;
                     r_next.hist_wr = 1'b1;
                  end
               endcase
            end
         end
         F_DECEL: begin
            if (STOPPED) begin
               r_next.fst = F_TRIP;
               r_next.hist_wr = 1'b1;
            end
         end
         F_AUTO: begin
            if (good_req) begin
               r_next.fst = F_OK;
               r_next.restart = 1'b1;
               r_next.hist_rst = 1'b1;
               r_next.sil_cnt = 14'h0000;
            end
         end
         F_COASTING, F_TRIP: begin
            if (clear_evt) begin
               r_next.fst = F_OK;
               r_next.err_cnt = 14'h0000;
               r_next.sil_arm = 1'b0;
            end
         end
         default: r_next.fst = F_OK;
      endcase

      // Commands are frozen during a fault so a restart reuses them
      if (CMD_UPD && r_reg.fst == F_OK) begin
         r_next.cmd_run = CMD_RUN;
         r_next.cmd_speed = CMD_SPEED;
      end

      // Parameter write storage target
      if (PARAM_WR) begin
         r_next.ram_wr = 1'b1;
         r_next.nv_wr = !r_reg.cfg.store_ram;
      end
   end

   // State register
   always_ff @(posedge CLK_SYS) begin
      if (RST) begin
         r_reg <= '0;
         r_reg.rx.sh <= FRAME_IDLE;
         r_reg.tx.sh <= FRAME_IDLE;
         r_reg.retry_lim <= RETRY_RST;
         r_reg.check_iv <= CHECK_RST;
         r_reg.link <= L_IDLE;
         r_reg.fst <= F_OK;
      end else begin
         r_reg <= r_next;
      end
   end

   // Outputs
   assign RDATA = r_reg.rdata;
   assign TXD = r_reg.tx.busy ? r_reg.tx.sh[0] : 1'b1;
   assign LINK_DE_N = !r_reg.tx.busy;
   assign RX_VALID = r_reg.rx_v;
   assign RX_DATA = r_reg.rx_d;
   assign TX_READY = (r_reg.link == L_REPLY) && !r_reg.tx.busy;
   assign REPLY_RETRY = r_reg.retry_rep;
   assign RUN_OUT = r_reg.cmd_run && (r_reg.fst == F_OK);
   assign SPEED_OUT = r_reg.cmd_speed;
   assign DECEL_STOP = (r_reg.fst == F_DECEL) || (r_reg.fst == F_AUTO);
   assign COAST_STOP = (r_reg.fst == F_COASTING);
   assign RESTART = r_reg.restart;
   assign FAULT_ALARM = (r_reg.fst == F_COASTING) || (r_reg.fst == F_TRIP);
   assign LINK_WARN = r_reg.warn;
   assign TRIP_CODE = (r_reg.fst == F_OK) ? 8'h00 : TRIP_CODE_DEF;
   assign HIST_WR = r_reg.hist_wr;
   assign HIST_TEMP = (r_reg.fst == F_AUTO);
   assign HIST_RESTORE = r_reg.hist_rst;
   assign NV_WR = r_reg.nv_wr;
   assign RAM_WR = r_reg.ram_wr;
endmodule

// [cl_link_ctrl_sva.sv]
`timescale 1ns/100ps
module cl_link_ctrl_chk import cl_pkg::*; #(
   parameter int CHECK_CYC = CHECK_UNIT_CYC,
   parameter int WAIT_CYC = WAIT_UNIT_CYC
) (
   input wire logic CLK_SYS,
   input wire logic RST,
   input wire logic TXD,
   input wire logic LINK_DE_N,
   input wire logic RX_VALID,
   input wire cl_req_t REQ,
   input wire logic REPLY_RETRY,
   input wire logic RUN_OUT,
   input wire logic DECEL_STOP,
   input wire logic COAST_STOP,
   input wire logic RESTART,
   input wire logic FAULT_ALARM,
   input wire logic [7:0] TRIP_CODE,
   input wire logic HIST_WR,
   input wire logic HIST_TEMP,
   input wire logic HIST_RESTORE,
   input wire logic PARAM_WR,
   input wire logic NV_WR,
   input wire logic RAM_WR
);
   default clocking cb @(posedge CLK_SYS); endclocking
   default disable iff (RST);
   // Fault indication and history
   alarm_code_a: assert property (FAULT_ALARM |-> TRIP_CODE != 8'h00)
      else $error("alarm shown without trip code");
   hist_write_a: assert property ($rose(FAULT_ALARM) |-> HIST_WR || $past(HIST_WR))
      else $error("alarm raised without history write");
   temp_hist_a: assert property (HIST_TEMP |-> !FAULT_ALARM && !HIST_WR)
      else $error("temporary history with fault output");
   restore_end_a: assert property (HIST_RESTORE |=> !HIST_TEMP)
      else $error("temporary history kept after restore");
   // Stop behaviour
   stop_excl_a: assert property (!(COAST_STOP && DECEL_STOP))
      else $error("coast and decel at once");
   stop_run_a: assert property ((COAST_STOP || DECEL_STOP) |-> !RUN_OUT)
      else $error("run kept during fault stop");
   restart_go_a: assert property (RESTART |=> !DECEL_STOP && !COAST_STOP)
      else $error("still stopping after restart");
   // Parameter storage
   store_ram_a: assert property (PARAM_WR |=> RAM_WR)
      else $error("parameter write missed RAM");
   store_nv_a: assert property (NV_WR |-> $past(PARAM_WR))
      else $error("NV write without parameter write");
   // Link side
   retry_reply_a: assert property ($rose(REPLY_RETRY) |-> $past(REQ.done))
      else $error("retry reply without request");
   tx_enable_a: assert property ($fell(TXD) |-> !LINK_DE_N)
      else $error("transmit with driver off");
   rx_pulse_a: assert property (RX_VALID |=> !RX_VALID)
      else $error("receive strobe too long");
   hist_wr_c: cover property (HIST_WR);
   restart_c: cover property (RESTART);
   rx_c: cover property (RX_VALID);
   temp_c: cover property (HIST_TEMP);
endmodule
bind cl_link_ctrl cl_link_ctrl_chk #(.CHECK_CYC(CHECK_CYC), .WAIT_CYC(WAIT_CYC)) chk (
   .CLK_SYS(CLK_SYS), .RST(RST), .TXD(TXD), .LINK_DE_N(LINK_DE_N), .RX_VALID(RX_VALID),
   .REQ(REQ), .REPLY_RETRY(REPLY_RETRY), .RUN_OUT(RUN_OUT), .DECEL_STOP(DECEL_STOP),
   .COAST_STOP(COAST_STOP), .RESTART(RESTART), .FAULT_ALARM(FAULT_ALARM),
   .TRIP_CODE(TRIP_CODE), .HIST_WR(HIST_WR), .HIST_TEMP(HIST_TEMP),
   .HIST_RESTORE(HIST_RESTORE), .PARAM_WR(PARAM_WR), .NV_WR(NV_WR), .RAM_WR(RAM_WR));

// [cl_host_model.sv]
`timescale 1ns/100ps
module cl_host_model import cl_pkg::*; #(
   parameter int BIT_CYC = CLK_HZ / BAUD_3
) (
   input wire logic clk,
   input wire logic txd,
   output logic rxd
);
   // Receive line idles high between frames
   initial rxd = 1'b1;
   // Start bit, seven data bits LSB first, one stop bit
   task send(input logic [6:0] ch);
      int i;
      @(posedge clk);
      rxd <= 1'b0;
      repeat (BIT_CYC) @(posedge clk);
      for (i = 0; i < 7; i++) begin
         rxd <= ch[i];
         repeat (BIT_CYC) @(posedge clk);
      end
      rxd <= 1'b1;
      repeat (BIT_CYC) @(posedge clk);
   endtask
   // Sample a reply frame mid-bit; bad stop bit gives 8'hee
   task get_char(output logic [7:0] ch);
      int i;
      int n;
      ch = 8'hff;
      n = 0;
      while (txd !== 1'b0 && n < 4000) begin
         @(posedge clk);
         n++;
      end
      if (n < 4000) begin
         repeat (BIT_CYC / 2) @(posedge clk);
         for (i = 0; i < 7; i++) begin
            repeat (BIT_CYC) @(posedge clk);
            ch[i] = txd;
         end
         ch[7] = 1'b0;
         repeat (BIT_CYC) @(posedge clk);
         if (txd !== 1'b1) ch = 8'hee;
      end
   endtask
endmodule

// [computer_link_slave_control_tb_top.sv]
`timescale 1ns/100ps
module computer_link_slave_control_tb_top import cl_pkg::*; ;
   localparam int BIT_CYC = CLK_HZ / BAUD_3;
   localparam int W_CYC = 5;
   logic CLK_SYS, RST, WR, RD, RXD, TXD, LINK_DE_N, RX_VALID, TX_VALID, TX_LAST, TX_READY;
   logic REPLY_RETRY, NET_MODE, CMD_UPD, CMD_RUN, STOPPED, RUN_OUT, DECEL_STOP, COAST_STOP;
   logic RESTART, FAULT_ALARM, LINK_WARN, HIST_WR, HIST_TEMP, HIST_RESTORE, PARAM_WR;
   logic NV_WR, RAM_WR;
   logic [7:0] ADDR, RX_DATA, TX_DATA, TRIP_CODE, c, got;
   logic [31:0] WDATA, RDATA, q, cfg;
   logic [15:0] CMD_SPEED, SPEED_OUT, sp;
   logic [4:0] oth;
   cl_req_t REQ;
   int errors, checks, seed, n, s;
   cl_link_ctrl #(.CHECK_CYC(20), .WAIT_CYC(W_CYC)) dut (
      .CLK_SYS(CLK_SYS), .RST(RST), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD),
      .RDATA(RDATA), .RXD(RXD), .TXD(TXD), .LINK_DE_N(LINK_DE_N), .RX_VALID(RX_VALID),
      .RX_DATA(RX_DATA), .REQ(REQ), .TX_VALID(TX_VALID), .TX_DATA(TX_DATA),
      .TX_LAST(TX_LAST), .TX_READY(TX_READY), .REPLY_RETRY(REPLY_RETRY),
      .NET_MODE(NET_MODE), .CMD_UPD(CMD_UPD), .CMD_RUN(CMD_RUN), .CMD_SPEED(CMD_SPEED),
      .STOPPED(STOPPED), .RUN_OUT(RUN_OUT), .SPEED_OUT(SPEED_OUT), .DECEL_STOP(DECEL_STOP),
      .COAST_STOP(COAST_STOP), .RESTART(RESTART), .FAULT_ALARM(FAULT_ALARM),
      .LINK_WARN(LINK_WARN), .TRIP_CODE(TRIP_CODE), .HIST_WR(HIST_WR),
      .HIST_TEMP(HIST_TEMP), .HIST_RESTORE(HIST_RESTORE), .PARAM_WR(PARAM_WR),
      .NV_WR(NV_WR), .RAM_WR(RAM_WR));
   cl_host_model #(.BIT_CYC(BIT_CYC)) host (.clk(CLK_SYS), .txd(TXD), .rxd(RXD));
   // Free-running system clock
   initial begin
      CLK_SYS = 1'b0;
      forever #5 CLK_SYS = ~CLK_SYS;
   end
   task summarize;
      if (errors == 0 && checks > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask
   task cmp(input logic [31:0] exp, input logic [31:0] seen, input string what);
      checks++;
      if (seen !== exp) begin
         errors++;
         $display("mismatch %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task tick;
      @(posedge CLK_SYS);
      #1;
   endtask
   task wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge CLK_SYS);
      ADDR <= a;
      WDATA <= d;
      WR <= 1'b1;
      @(posedge CLK_SYS);
      WR <= 1'b0;
   endtask
   task rd(input logic [7:0] a, output logic [31:0] d);
      @(posedge CLK_SYS);
      ADDR <= a;
      RD <= 1'b1;
      @(posedge CLK_SYS);
      RD <= 1'b0;
      #1 d = RDATA;
   endtask
   task req(input logic [4:0] stn, input logic ack, input logic bad);
      @(posedge CLK_SYS);
      REQ <= '{done: 1'b1, ack: ack, sum_err: bad, station: stn};
      @(posedge CLK_SYS);
      REQ <= '0;
      #1;
   endtask
   // Offer one last reply character while the host decodes the wire
   task reply(input logic [7:0] ch, output logic [7:0] seen);
      fork
         host.get_char(seen);
         begin
            @(posedge CLK_SYS);
            TX_VALID <= 1'b1;
            TX_DATA <= ch;
            TX_LAST <= 1'b1;
            #1;
            while (TX_READY !== 1'b1) tick;
            @(posedge CLK_SYS);
            TX_VALID <= 1'b0;
            TX_LAST <= 1'b0;
         end
      join
   endtask
   // Watchdog sized well past the three serial frames of the run
   initial begin
      #1_000_000;
      errors++;
      summarize;
   end
   // Main sequence
   initial begin
      errors = 0;
      checks = 0;
      seed = 32'h14d3;
      RST = 1'b1; WR = 1'b0; RD = 1'b0; ADDR = 8'h00; WDATA = 32'h0; REQ = '0;
      TX_VALID = 1'b0; TX_DATA = 8'h00; TX_LAST = 1'b0; NET_MODE = 1'b1; CMD_UPD = 1'b0;
      CMD_RUN = 1'b0; CMD_SPEED = 16'h0; STOPPED = 1'b0; PARAM_WR = 1'b0;
      repeat (5) @(posedge CLK_SYS);
      RST <= 1'b0;
      rd(A_STAT, q); cmp(32'(F_OK) << S_FST, q, "status reset");
      rd(A_RETRY, q); cmp(32'(RETRY_RST), q, "retry reset");
      rd(A_CHECK, q); cmp(32'(CHECK_RST), q, "check reset");
      rd(8'h1c, q); cmp(32'h0, q, "unmapped read");
      cfg = 32'h5 | (32'h3 << F_RATE) | (32'h1 << F_WAITEN);
      wr(A_WAIT, 32'h2);
      wr(A_RETRY, 32'h2);
      wr(A_STOP, 32'(SM_DECEL));
      wr(A_CHECK, 32'(NO_LIMIT));
      // Storage target follows the select bit
      for (s = 0; s < 2; s++) begin
         wr(A_CFG, cfg | (32'(s) << F_STORE));
         @(posedge CLK_SYS);
         PARAM_WR <= 1'b1;
         @(posedge CLK_SYS);
         PARAM_WR <= 1'b0;
         #1 cmp(32'h1, 32'(RAM_WR), "ram write");
         cmp(32'(s == 0), 32'(NV_WR), "nv write");
      end
      // Other station and host acknowledge get no reply
      oth = 5'd6 + 5'($unsigned($random(seed)) % 26);
      req(oth, 1'b0, 1'b0);
      req(5'd5, 1'b1, 1'b0);
      n = 0;
      repeat (30) begin
         tick;
         if (TX_READY !== 1'b0 || LINK_DE_N !== 1'b1) n++;
      end
      cmp(32'h0, 32'(n), "unaddressed reply");
      // Bad request: retry reply after the wait time
      req(5'd5, 1'b0, 1'b1);
      cmp(32'h1, 32'(REPLY_RETRY), "retry reply");
      n = 0;
      while (TX_READY !== 1'b1 && n < 100) begin
         tick;
         n++;
      end
      cmp(32'h1, 32'(n >= 2 * W_CYC - 1 && n <= 2 * W_CYC + 3), "wait cycles");
      c = 8'($random(seed)) & 8'h7f;
      reply(c, got);
      cmp(32'(c), 32'(got), "reply char");
      rd(A_STAT, q); cmp(32'h1, 32'(q[S_ERRC +: 14]), "error count");
      repeat (BIT_CYC) @(posedge CLK_SYS);
      // Host character on the receive line
      c = 8'($random(seed)) & 8'h7f;
      fork
         host.send(c[6:0]);
         begin
            n = 0;
            while (RX_VALID !== 1'b1 && n < 12 * BIT_CYC) begin
               tick;
               n++;
            end
            cmp(32'(c), 32'(RX_DATA), "rx char");
         end
      join
      // Second bad request reaches the limit: decel, alarm after stop
      req(5'd5, 1'b0, 1'b1);
      n = 0;
      while (DECEL_STOP !== 1'b1 && n < 50) begin
         tick;
         n++;
      end
      cmp(32'h1, 32'(DECEL_STOP), "decel stop");
      cmp(32'h0, 32'(FAULT_ALARM), "alarm before stop");
      @(posedge CLK_SYS);
      STOPPED <= 1'b1;
      n = 0;
      while (FAULT_ALARM !== 1'b1 && n < 50) begin
         tick;
         n++;
      end
      cmp(32'h1, 32'(HIST_WR), "history write");
      cmp(32'(TRIP_CODE_DEF), 32'(TRIP_CODE), "trip code");
      rd(A_STAT, q); cmp(32'h1, 32'(q[S_ALM]), "alarm bit");
      wr(A_CTRL, 32'h1 << F_CLR);
      tick;
      cmp(32'h0, 32'(FAULT_ALARM), "alarm cleared");
      // Fresh start in auto-restart mode with silence check
      @(posedge CLK_SYS);
      RST <= 1'b1;
      STOPPED <= 1'b0;
      repeat (2) @(posedge CLK_SYS);
      RST <= 1'b0;
      wr(A_CFG, 32'h5 | (32'h3 << F_RATE));
      wr(A_STOP, 32'(SM_AUTO));
      wr(A_CHECK, 32'h1);
      sp = 16'($random(seed));
      @(posedge CLK_SYS);
      CMD_UPD <= 1'b1;
      CMD_RUN <= 1'b1;
      CMD_SPEED <= sp;
      @(posedge CLK_SYS);
      CMD_UPD <= 1'b0;
      tick;
      tick;
      cmp(32'(sp), 32'(SPEED_OUT), "speed cmd");
      req(5'd5, 1'b0, 1'b0);
      n = 0;
      while (TX_READY !== 1'b1 && n < 100) begin
         tick;
         n++;
      end
      cmp(32'h1, 32'(n <= 3), "no wait");
      c = 8'($random(seed)) & 8'h7f;
      fork
         reply(c, got);
         begin
            n = 0;
            while (DECEL_STOP !== 1'b1 && n < 100) begin
               tick;
               n++;
            end
            cmp(32'h1, 32'(DECEL_STOP), "silence trip");
            cmp(32'h1, 32'(HIST_TEMP), "temp history");
            cmp(32'h0, 32'(FAULT_ALARM), "no alarm");
            @(posedge CLK_SYS);
            CMD_UPD <= 1'b1;
            CMD_SPEED <= ~sp;
            @(posedge CLK_SYS);
            CMD_UPD <= 1'b0;
         end
      join
      cmp(32'(c), 32'(got), "reply char 2");
      repeat (BIT_CYC) @(posedge CLK_SYS);
      // Clean request removes the error while still decelerating
      req(5'd5, 1'b0, 1'b0);
      n = 0;
      while (RESTART !== 1'b1 && n < 20) begin
         tick;
         n++;
      end
      cmp(32'h1, 32'(RESTART), "restart");
      cmp(32'h1, 32'(HIST_RESTORE), "history restore");
      tick;
      tick;
      cmp(32'h1, 32'(RUN_OUT), "run restored");
      cmp(32'(sp), 32'(SPEED_OUT), "speed restored");
      cmp(32'h0, 32'(HIST_TEMP), "history restored");
      summarize;
   end
endmodule
